// ### serial_tx_rx_flags_core.sv
// Serial transmitter with buffer flags, receiver with frame capture, and the receive FIFO.
//
// Summary of operation
// (RULE_01) Buffer-empty flag is high when the transmit buffer is empty, low while data waits.
// (RULE_02) A data write loads the transmit buffer and clears the buffer-empty flag.
// (RULE_03) Buffer-empty request stays asserted while its enable and the flag are set.
// (RULE_04) Software must refill the buffer or drop the enable, else the request repeats.
// (RULE_05) Finished flag sets when the frame is shifted out and the buffer is empty.
// (RULE_06) Finished flag clears on interrupt service or on a write of one.
// (RULE_07) Finished request follows the flag while its enable is set.
// (RULE_08) Software writes zero into the buffer-empty flag position.
// (RULE_09) With parity enabled, parity goes between the last data bit and first stop bit.
// (RULE_10) Clearing transmit enable acts only after shifter and buffer are both empty.
// (RULE_11) A disabled transmitter releases the transmit pin to ordinary port use.
// (RULE_12) Receive enable hands the receive pin to the receiver as serial input.
// (RULE_13) In synchronous mode the receiver samples on the external transfer clock.
// (RULE_14) Reception starts on a valid start bit, then shifts bits up to the first stop.
// (RULE_15) A second stop bit is ignored; the frame ends on the first stop bit.
// (RULE_16) On the first stop bit the frame moves into the receive buffer.
// (RULE_17) Characters under eight bits read back with zero upper bits.
// (RULE_18) The ninth transmit bit is sent as an ordinary data bit.
// (RULE_19) Software sets the ninth bit before writing the low byte.
// (RULE_20) Frame: low start, data LSB first, optional parity, high stops; idle high.
// (RULE_21) Parity is the xor of the data bits, inverted for odd parity.
// (RULE_22) The shifter loads when idle or right after the last stop bit.
// (RULE_23) Requests are level outputs; the controller returns a serviced acknowledge.
`default_nettype none

module serial_rx_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic flush,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW-1:0] wr_ptr;
      logic [AW-1:0] rd_ptr;
      logic [AW:0] count;
   } fifo_state_s;
   fifo_state_s st, next_st;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push, pop;

   assign in_ready = (st.count != (AW+1)'(DEPTH));
   assign out_valid = (st.count != '0);
   assign out_data = mem[st.rd_ptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      next_st = st;
      if (push) begin
         next_st.wr_ptr = st.wr_ptr + 1'b1;
      end
      if (pop) begin
         next_st.rd_ptr = st.rd_ptr + 1'b1;
      end
      next_st.count = st.count + (AW+1)'(push) - (AW+1)'(pop);
      if (flush) begin
         next_st = '0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // The array has no reset; the count keeps stale words from being seen.
   always_ff @(posedge clk) begin
      if (push) begin
         mem[st.wr_ptr] <= in_data;
      end
   end
endmodule

module serial_tx_rx_flags_core (
   input wire logic REF_CLK,
   input wire logic SYS_RST,
   input wire logic BAUD_TICK_X16,
   input wire logic SYNC_MODE,
   input wire logic [2:0] CHAR_SIZE_CODE,
   input wire logic PARITY_MODE_HI,
   input wire logic PARITY_MODE_LO,
   input wire logic STOP_BITS_TWO,
   input wire logic TX_ENABLE_BIT,
   input wire logic RX_ENABLE_BIT,
   input wire logic TX_BUFFER_EMPTY_IRQ_EN,
   input wire logic TX_FINISHED_IRQ_EN,
   input wire logic TX_DATA_WR,
   input wire logic [7:0] TX_DATA,
   input wire logic TX_NINTH_BIT,
   input wire logic TX_FINISHED_CLR_WR,
   input wire logic TX_FINISHED_IRQ_ACK,
   output logic TX_BUFFER_EMPTY_FLAG,
   output logic TX_FINISHED_FLAG,
   output logic IRQ_TX_BUFFER_EMPTY,
   output logic IRQ_TX_FINISHED,
   output logic TXD_PIN,
   output logic TXD_OE,
   input wire logic RXD_PIN,
   output logic RX_PIN_OWNED,
   input wire logic EXT_TRANSFER_CLOCK_PIN,
   output logic RX_COMPLETE_FLAG,
   output logic [7:0] RX_DATA,
   input wire logic RX_DATA_READ
);
   typedef struct packed {
      logic [1:0] rxd_sync;
      logic [2:0] xck_sync;
      logic buf_valid;
      logic [8:0] buf_data;
      logic tx_active;
      serial_core_pkg::tx_frame_s tx_frame;
      logic [3:0] tx_os;
      logic tx_finished;
      serial_core_pkg::rx_state_e rx_state;
      logic [3:0] rx_os;
      logic [3:0] rx_idx;
      logic [7:0] rx_shift;
   } core_state_s;
   core_state_s st, next_st;

   serial_core_pkg::frame_cfg_s cfg;
   logic rxd, xck_rise, xck_fall, tx_bit_end, tx_last_end, tx_load, rx_sample;
   logic [3:0] rx_nbits, rx_stop_idx;
   logic fifo_ready;

   // Parity covers only the bits the character size actually sends.
   function automatic serial_core_pkg::tx_frame_s build_frame(input logic [8:0] d,
         input serial_core_pkg::frame_cfg_s c);
      serial_core_pkg::tx_frame_s f;
      logic [3:0] n;
      logic par;
      n = serial_core_pkg::data_bits(c.char_size_code);
      par = c.parity_odd;
      f.bits = '1;
      f.bits[0] = 1'b0; // [RULE_20]
      for (int i = 0; i < 9; i++) begin
         if (4'(i) < n) begin
            f.bits[i+1] = d[i]; // [RULE_18] [RULE_20]
            par = par ^ d[i]; // [RULE_21]
         end
      end
      if (c.parity_mode_hi) begin
         f.bits[n+4'h1] = par; // [RULE_09]
      end
      f.len = 4'h2 + n + 4'(c.parity_mode_hi) + 4'(c.two_stop);
      return f;
   endfunction

   assign cfg = '{CHAR_SIZE_CODE, PARITY_MODE_HI, PARITY_MODE_LO, STOP_BITS_TWO};
   assign rxd = st.rxd_sync[1];
   assign xck_rise = st.xck_sync[1] && !st.xck_sync[2];
   assign xck_fall = !st.xck_sync[1] && st.xck_sync[2];

   // Synchronous mode shifts out on the falling edge so the far end samples on the rising one.
   assign tx_bit_end = st.tx_active &&
      (SYNC_MODE ? xck_fall : (BAUD_TICK_X16 && st.tx_os == serial_core_pkg::OS_LAST));
   assign tx_last_end = tx_bit_end && st.tx_frame.len == serial_core_pkg::IDX_ONE;
   assign tx_load = st.buf_valid && (!st.tx_active || tx_last_end); // [RULE_22]

   assign rx_nbits = serial_core_pkg::data_bits(CHAR_SIZE_CODE);
   assign rx_stop_idx = rx_nbits + 4'(PARITY_MODE_HI);
   assign rx_sample = SYNC_MODE ? xck_rise : // [RULE_13]
      (BAUD_TICK_X16 &&
       st.rx_os == ((st.rx_state == serial_core_pkg::RX_START) ?
                    serial_core_pkg::OS_MID : serial_core_pkg::OS_LAST));

   always_comb begin
      next_st = st;
      next_st.rxd_sync = {st.rxd_sync[0], RXD_PIN};
      next_st.xck_sync = {st.xck_sync[1:0], EXT_TRANSFER_CLOCK_PIN};
      // Transmit buffer and shifter.
      if (tx_load) begin
         next_st.buf_valid = 1'b0; // [RULE_01]
      end
      if (TX_DATA_WR) begin
         next_st.buf_valid = 1'b1; // [RULE_02]
         next_st.buf_data = {TX_NINTH_BIT, TX_DATA};
      end
      if (st.tx_active && !SYNC_MODE && BAUD_TICK_X16) begin
         next_st.tx_os = st.tx_os + 4'h1;
      end
      if (tx_bit_end) begin
         next_st.tx_frame.bits = {1'b1, st.tx_frame.bits[serial_core_pkg::FRAME_W-1:1]};
         next_st.tx_frame.len = st.tx_frame.len - 4'h1;
         if (tx_last_end) begin
            next_st.tx_active = 1'b0;
         end
      end
      if (tx_load) begin
         next_st.tx_active = 1'b1;
         next_st.tx_os = '0;
         next_st.tx_frame = build_frame(st.buf_data, cfg);
      end
      // Set wins over either clear.
      if (TX_FINISHED_IRQ_ACK || TX_FINISHED_CLR_WR) begin
         next_st.tx_finished = 1'b0; // [RULE_06] [RULE_23]
      end
      if (tx_last_end && !st.buf_valid) begin
         next_st.tx_finished = 1'b1; // [RULE_05]
      end
      // Receiver.
      if (BAUD_TICK_X16 && !SYNC_MODE) begin
         next_st.rx_os = st.rx_os + 4'h1;
      end
      case (st.rx_state)
         serial_core_pkg::RX_IDLE: begin
            next_st.rx_idx = '0;
            next_st.rx_shift = '0; // [RULE_17]
            if (SYNC_MODE) begin
               if (xck_rise && !rxd) begin
                  next_st.rx_state = serial_core_pkg::RX_BITS; // [RULE_14]
               end
            end else if (!rxd) begin
               next_st.rx_state = serial_core_pkg::RX_START;
               next_st.rx_os = '0;
            end
         end
         serial_core_pkg::RX_START: begin
            if (rx_sample) begin
               next_st.rx_os = '0;
               // A glitch shorter than half a bit is not a start bit.
               next_st.rx_state = rxd ? serial_core_pkg::RX_IDLE :
                  serial_core_pkg::RX_BITS; // [RULE_14]
            end
         end
         serial_core_pkg::RX_BITS: begin
            if (rx_sample) begin
               if (st.rx_idx < rx_nbits && st.rx_idx < serial_core_pkg::STORE_LIMIT) begin
                  next_st.rx_shift[st.rx_idx[2:0]] = rxd; // [RULE_14]
               end
               next_st.rx_idx = st.rx_idx + 4'h1;
               if (st.rx_idx == rx_stop_idx) begin
                  next_st.rx_state = serial_core_pkg::RX_HOLD; // [RULE_15] [RULE_16]
               end
            end
         end
         serial_core_pkg::RX_HOLD: begin
            // A full buffer stalls here; frames arriving meanwhile are lost.
            if (fifo_ready) begin
               next_st.rx_state = serial_core_pkg::RX_IDLE; // [RULE_16]
            end
         end
         default: begin
            next_st.rx_state = serial_core_pkg::RX_IDLE;
         end
      endcase
      if (!RX_ENABLE_BIT) begin
         next_st.rx_state = serial_core_pkg::RX_IDLE;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         st <= '0;
         st.rxd_sync <= 2'h3;
         st.buf_data <= '0;
         st.tx_frame.bits <= '1;
         st.rx_state <= serial_core_pkg::RX_IDLE;
      end else begin
         st <= next_st;
      end
   end

   serial_rx_fifo #(
      .WIDTH(serial_core_pkg::DATA_W),
      .DEPTH(serial_core_pkg::RX_DEPTH)
   ) u_rx_fifo (
      .clk(REF_CLK),
      .rst(SYS_RST),
      .flush(!RX_ENABLE_BIT),
      .in_valid(st.rx_state == serial_core_pkg::RX_HOLD),
      .in_ready(fifo_ready),
      .in_data(st.rx_shift),
      .out_valid(RX_COMPLETE_FLAG),
      .out_ready(RX_DATA_READ),
      .out_data(RX_DATA)
   );

   assign TX_BUFFER_EMPTY_FLAG = !st.buf_valid; // [RULE_01]
   assign TX_FINISHED_FLAG = st.tx_finished;
   assign IRQ_TX_BUFFER_EMPTY = TX_BUFFER_EMPTY_IRQ_EN && !st.buf_valid; // [RULE_03] [RULE_23]
   assign IRQ_TX_FINISHED = TX_FINISHED_IRQ_EN && st.tx_finished; // [RULE_07] [RULE_23]
   assign TXD_OE = TX_ENABLE_BIT || st.tx_active || st.buf_valid; // [RULE_10] [RULE_11]
   assign TXD_PIN = st.tx_frame.bits[0]; // [RULE_20]
   assign RX_PIN_OWNED = RX_ENABLE_BIT; // [RULE_12]

   sequence s_last_bit_no_data;
      tx_last_end && !st.buf_valid;
   endsequence

   property p_write_clears_empty;
      @(posedge REF_CLK) disable iff (SYS_RST) TX_DATA_WR |=> !TX_BUFFER_EMPTY_FLAG;
   endproperty
   a_write_clears_empty: assert property (p_write_clears_empty) // [RULE_02]
      else $error("Buffer-empty flag did not clear after a write.");

   property p_empty_rises_on_load;
      @(posedge REF_CLK) disable iff (SYS_RST) $rose(TX_BUFFER_EMPTY_FLAG) |-> $past(tx_load);
   endproperty
   a_empty_rises_on_load: assert property (p_empty_rises_on_load) // [RULE_01]
      else $error("Buffer-empty flag rose without a shifter load.");

   property p_empty_irq;
      @(posedge REF_CLK) disable iff (SYS_RST)
         (TX_BUFFER_EMPTY_IRQ_EN && TX_BUFFER_EMPTY_FLAG) |-> IRQ_TX_BUFFER_EMPTY;
   endproperty
   a_empty_irq: assert property (p_empty_irq) // [RULE_03]
      else $error("Buffer-empty request missing.");

   property p_finished_sets;
      @(posedge REF_CLK) disable iff (SYS_RST) s_last_bit_no_data |=> TX_FINISHED_FLAG;
   endproperty
   a_finished_sets: assert property (p_finished_sets) // [RULE_05]
      else $error("Finished flag did not set after the last bit.");

   property p_finished_clears;
      @(posedge REF_CLK) disable iff (SYS_RST)
         (TX_FINISHED_IRQ_ACK && !tx_last_end) |=> !TX_FINISHED_FLAG;
   endproperty
   a_finished_clears: assert property (p_finished_clears) // [RULE_06]
      else $error("Finished flag survived the serviced acknowledge.");

   property p_finished_irq;
      @(posedge REF_CLK) disable iff (SYS_RST)
         (TX_FINISHED_IRQ_EN && $rose(TX_FINISHED_FLAG)) |-> IRQ_TX_FINISHED;
   endproperty
   a_finished_irq: assert property (p_finished_irq) // [RULE_07]
      else $error("Finished request missing.");

   property p_start_bit_low;
      @(posedge REF_CLK) disable iff (SYS_RST) tx_load |=> !TXD_PIN && TXD_OE;
   endproperty
   a_start_bit_low: assert property (p_start_bit_low) // [RULE_20]
      else $error("Frame did not open with a low start bit.");

   property p_disable_waits;
      @(posedge REF_CLK) disable iff (SYS_RST)
         $fell(TXD_OE) |-> !$past(st.buf_valid) && (!$past(st.tx_active) || $past(tx_last_end));
   endproperty
   a_disable_waits: assert property (p_disable_waits) // [RULE_10]
      else $error("Transmitter released the pin with data pending.");

   property p_release_pin;
      @(posedge REF_CLK) disable iff (SYS_RST)
         (!TX_ENABLE_BIT && tx_last_end && !st.buf_valid && !TX_DATA_WR)
         |=> (!TXD_OE || TX_ENABLE_BIT);
   endproperty
   a_release_pin: assert property (p_release_pin) // [RULE_11]
      else $error("Disabled idle transmitter still drives the pin.");

   property p_hold_pushes;
      @(posedge REF_CLK) disable iff (SYS_RST)
         (st.rx_state == serial_core_pkg::RX_HOLD && fifo_ready && RX_ENABLE_BIT)
         |=> RX_COMPLETE_FLAG;
   endproperty
   a_hold_pushes: assert property (p_hold_pushes) // [RULE_16]
      else $error("Received frame did not reach the receive buffer.");
endmodule
`default_nettype wire

// ### serial_core_pkg.sv
// Shared constants, types and helpers of the serial transmit and receive core.
`default_nettype none
package serial_core_pkg;
   localparam int DATA_W = 8;
   localparam int RX_DEPTH = 32;
   localparam int FRAME_W = 13;
   localparam logic [2:0] CSZ_NINE = 3'h7;
   localparam logic [3:0] OS_LAST = 4'hF;
   localparam logic [3:0] OS_MID = 4'h7;
   localparam logic [3:0] IDX_ZERO = 4'h0;
   localparam logic [3:0] IDX_ONE = 4'h1;
   localparam logic [3:0] BITS_FIVE = 4'h5;
   localparam logic [3:0] BITS_EIGHT = 4'h8;
   localparam logic [3:0] BITS_NINE = 4'h9;
   localparam logic [3:0] STORE_LIMIT = 4'h8;

   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_HOLD} rx_state_e;

   typedef struct packed {
      logic [2:0] char_size_code;
      logic parity_mode_hi;
      logic parity_odd;
      logic two_stop;
   } frame_cfg_s;

   typedef struct packed {
      logic [3:0] len;
      logic [FRAME_W-1:0] bits;
   } tx_frame_s;

   // Character sizes 0..3 give 5..8 bits, code 7 gives 9; reserved codes fall back to 8.
   function automatic logic [3:0] data_bits(input logic [2:0] code);
      logic [3:0] n;
      n = BITS_EIGHT;
      if (code == CSZ_NINE) begin
         n = BITS_NINE;
      end else if (code[2] == 1'b0) begin
         n = BITS_FIVE + {2'h0, code[1:0]};
      end
      return n;
   endfunction
endpackage
`default_nettype wire

// ### serial_remote_model.sv
// Remote serial transceiver model: sends frames on the receive line and samples the transmit line.
`default_nettype none
module serial_remote_model (
   input wire logic clk,
   input wire logic txd,
   output logic rxd,
   output logic ext_transfer_clock_pin
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam int BIT_CYC = 16;
   // The line rests high and the transfer clock rests low between frames.
   initial begin
      rxd = 1'b1;
      ext_transfer_clock_pin = 1'b0;
   end
   // Samples each bit at its middle; returns at the middle of the last bit, so a
   // following start edge is never missed.
   task automatic get_frame(input int n, output logic [12:0] bits);
      bits = '1;
      @(negedge txd);
      repeat (BIT_CYC / 2) @(posedge clk);
      bits[0] = txd;
      for (int i = 1; i < n; i++) begin
         repeat (BIT_CYC) @(posedge clk);
         bits[i] = txd;
      end
   endtask
   // Synchronous bits change while the transfer clock is low and hold across its rise.
   task automatic send(input logic [12:0] bits, input int n, input logic sync);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         #1 rxd = bits[i];
         if (sync) begin
            repeat (4) @(posedge clk);
            #1 ext_transfer_clock_pin = 1'b1;
            repeat (4) @(posedge clk);
            #1 ext_transfer_clock_pin = 1'b0;
         end else begin
            repeat (BIT_CYC - 1) @(posedge clk);
         end
      end
      // Returns just off the edge so the caller never drives in the sampling time step.
      #1 rxd = 1'b1;
   endtask
endmodule
`default_nettype wire

// ### serial_tx_rx_flags_core_tb.sv
// Self-checking testbench of the serial transmit and receive core.
`default_nettype none
module serial_tx_rx_flags_core_tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int DLY = 1;
   localparam int LIMIT = 20000;
   logic ref_clk, sys_rst, tick, sync, tx_en, rx_en, be_en, fin_en, wr, ninth, fin_clr, fin_ack;
   logic rd, tx_empty, tx_fin, irq_be, irq_fin, txd, txd_oe, rxd, owned, ext_transfer_clock_pin, rx_flag;
   logic [7:0] tx_data, rx_data;
   serial_core_pkg::frame_cfg_s cfg;
   int bad_count = 0;
   int num_checks = 0;
   int cycles = 0;

   serial_tx_rx_flags_core dut (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .BAUD_TICK_X16(tick),
      .SYNC_MODE(sync), .CHAR_SIZE_CODE(cfg.char_size_code), .PARITY_MODE_HI(cfg.parity_mode_hi),
      .PARITY_MODE_LO(cfg.parity_odd), .STOP_BITS_TWO(cfg.two_stop), .TX_ENABLE_BIT(tx_en),
      .RX_ENABLE_BIT(rx_en), .TX_BUFFER_EMPTY_IRQ_EN(be_en), .TX_FINISHED_IRQ_EN(fin_en),
      .TX_DATA_WR(wr), .TX_DATA(tx_data), .TX_NINTH_BIT(ninth), .TX_FINISHED_CLR_WR(fin_clr),
      .TX_FINISHED_IRQ_ACK(fin_ack), .TX_BUFFER_EMPTY_FLAG(tx_empty), .TX_FINISHED_FLAG(tx_fin),
      .IRQ_TX_BUFFER_EMPTY(irq_be), .IRQ_TX_FINISHED(irq_fin), .TXD_PIN(txd), .TXD_OE(txd_oe),
      .RXD_PIN(rxd), .RX_PIN_OWNED(owned), .EXT_TRANSFER_CLOCK_PIN(ext_transfer_clock_pin),
      .RX_COMPLETE_FLAG(rx_flag), .RX_DATA(rx_data), .RX_DATA_READ(rd));
   serial_remote_model rem (.clk(ref_clk), .txd(txd), .rxd(rxd), .ext_transfer_clock_pin(ext_transfer_clock_pin));

   task automatic final_report();
      $display("Checks %0d, errors %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk_bit(input logic got, input logic exp, input string msg);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %0t %s got %b exp %b", $time, msg, got, exp);
      end
   endtask
   task automatic chk_vec(input logic [12:0] got, input logic [12:0] exp, input string msg);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   function automatic int nbits(input logic [2:0] c);
      return (c == 3'h7) ? 9 : ((c < 3'h4) ? 5 + int'(c) : 8);
   endfunction
   function automatic serial_core_pkg::tx_frame_s make_frame(input logic [8:0] d,
         input logic [2:0] c, input logic [2:0] m);
      serial_core_pkg::tx_frame_s f;
      logic p;
      f.bits = '1;
      f.bits[0] = 1'b0;
      p = m[1];
      for (int i = 0; i < nbits(c); i++) begin
         f.bits[i + 1] = d[i];
         p = p ^ d[i];
      end
      if (m[2]) begin
         f.bits[nbits(c) + 1] = p;
      end
      f.len = 4'(nbits(c) + 2 + int'(m[2]) + int'(m[0]));
      return f;
   endfunction
   task automatic step();
      @(posedge ref_clk);
      #DLY;
   endtask
   task automatic wr_byte(input logic [8:0] d);
      step();
      wr = 1'b1;
      tx_data = d[7:0];
      ninth = d[8];
      step();
      wr = 1'b0;
   endtask
   task automatic wait_fin();
      for (int k = 0; k < 40 && tx_fin !== 1'b1; k++) begin
         step();
      end
      chk_bit(tx_fin, 1'b1, "finished flag");
   endtask
   task automatic wait_rx();
      for (int k = 0; k < 60 && rx_flag !== 1'b1; k++) begin
         step();
      end
      chk_bit(rx_flag, 1'b1, "receive flag");
   endtask
   task automatic pop();
      step();
      rd = 1'b1;
      step();
      rd = 1'b0;
   endtask

   task automatic reset_case();
      chk_bit(tx_empty, 1'b1, "empty at reset");
      chk_bit(irq_be, 1'b1, "empty request at reset");
      chk_bit(tx_fin, 1'b0, "finished at reset");
      chk_bit(txd, 1'b1, "idle line");
      chk_bit(rx_flag, 1'b0, "receive flag at reset");
      chk_bit(owned, 1'b1, "receive pin owned");
   endtask
   // One frame out; the finished flag is cleared by acknowledge or by a write of one.
   task automatic tx_case(input logic [8:0] d, input logic [2:0] c, input logic [2:0] m,
         input logic ack);
      serial_core_pkg::tx_frame_s f;
      logic [12:0] got;
      cfg = '{c, m[2], m[1], m[0]};
      f = make_frame(d, c, m);
      fork
         rem.get_frame(int'(f.len), got);
         begin
            wr_byte(d);
            chk_bit(tx_empty, 1'b0, "empty after write");
            step();
            chk_bit(tx_empty, 1'b1, "empty after load");
            chk_bit(irq_be, 1'b1, "empty request");
         end
      join
      chk_vec(got, f.bits, "tx frame");
      chk_bit(tx_fin, 1'b0, "finished early");
      wait_fin();
      chk_bit(irq_fin, 1'b1, "finished request");
      fin_ack = ack;
      fin_clr = ~ack;
      step();
      fin_ack = 1'b0;
      fin_clr = 1'b0;
      chk_bit(tx_fin, 1'b0, "finished cleared");
      chk_bit(tx_empty, 1'b1, "empty kept by clear write");
      chk_bit(irq_fin, 1'b0, "finished request dropped");
   endtask
   // Second byte waits in the buffer while the enable is dropped mid-frame.
   task automatic b2b_case();
      logic [12:0] g1, g2;
      cfg = '{3'h3, 1'b0, 1'b0, 1'b0};
      fork
         begin
            rem.get_frame(10, g1);
            chk_bit(txd_oe, 1'b1, "pin held while pending");
            rem.get_frame(10, g2);
         end
         begin
            wr_byte(9'h03C);
            wr_byte(9'h0C3);
            chk_bit(tx_empty, 1'b0, "second byte waits");
            chk_bit(irq_be, 1'b0, "no empty request");
            tx_en = 1'b0;
         end
      join
      chk_vec(g1, {3'h7, 1'b1, 8'h3C, 1'b0}, "first frame");
      chk_vec(g2, {3'h7, 1'b1, 8'hC3, 1'b0}, "second frame");
      chk_bit(tx_fin, 1'b0, "finished between frames");
      wait_fin();
      step();
      chk_bit(txd_oe, 1'b0, "pin released");
      be_en = 1'b0;
      step();
      chk_bit(irq_be, 1'b0, "masked empty request");
      be_en = 1'b1;
      tx_en = 1'b1;
      fin_ack = 1'b1;
      step();
      fin_ack = 1'b0;
   endtask
   // Frame in, checked at the head of the buffer, then popped; short sends drop the second stop.
   task automatic rx_case(input logic [8:0] d, input logic [2:0] c, input logic [2:0] m,
         input logic sy);
      serial_core_pkg::tx_frame_s f;
      logic [8:0] mask;
      cfg = '{c, m[2], m[1], m[0]};
      sync = sy;
      f = make_frame(d, c, m);
      mask = (9'h001 << nbits(c)) - 9'h001;
      rem.send(f.bits, int'(f.len) - int'(m[0]), sy);
      wait_rx();
      chk_vec({5'h00, rx_data}, {5'h00, d[7:0] & mask[7:0]}, "rx data");
      pop();
      chk_bit(rx_flag, 1'b0, "buffer empty after read");
      sync = 1'b0;
   endtask
   // Fills the buffer past its depth; the extra frame waits in the receiver until room appears.
   task automatic fifo_case();
      cfg = '{3'h3, 1'b0, 1'b0, 1'b0};
      for (int i = 0; i <= serial_core_pkg::RX_DEPTH; i++) begin
         rem.send({3'h7, 1'b1, 8'(8'h40 + i), 1'b0}, 10, 1'b0);
      end
      for (int i = 0; i <= serial_core_pkg::RX_DEPTH; i++) begin
         wait_rx();
         chk_vec({5'h00, rx_data}, {5'h00, 8'(8'h40 + i)}, "fifo order");
         pop();
      end
      chk_bit(rx_flag, 1'b0, "fifo drained");
      rem.send({3'h7, 1'b1, 8'h5A, 1'b0}, 10, 1'b0);
      wait_rx();
      rx_en = 1'b0;
      step();
      chk_bit(rx_flag, 1'b0, "flushed on disable");
      chk_bit(owned, 1'b0, "receive pin released");
      rx_en = 1'b1;
   endtask

   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         bad_count++;
         final_report();
      end
   end
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   initial begin
      {tx_en, rx_en, be_en, fin_en, tick, sys_rst} = 6'h3F;
      {sync, wr, ninth, fin_clr, fin_ack, rd} = 6'h00;
      tx_data = 8'h00;
      cfg = '{3'h3, 1'b0, 1'b0, 1'b0};
      repeat (10) @(posedge ref_clk);
      #DLY;
      sys_rst = 1'b0;
      repeat (3) step();
      reset_case();
      tx_case(9'h0A5, 3'h3, 3'h0, 1'b1);
      tx_case(9'h0B4, 3'h3, 3'h4, 1'b0);
      tx_case(9'h0F3, 3'h0, 3'h6, 1'b1);
      tx_case(9'h02D, 3'h1, 3'h5, 1'b0);
      tx_case(9'h07E, 3'h2, 3'h6, 1'b1);
      tx_case(9'h155, 3'h7, 3'h4, 1'b0);
      tx_case(9'h0E1, 3'h5, 3'h1, 1'b1);
      b2b_case();
      rx_case(9'h0FF, 3'h0, 3'h4, 1'b0);
      rx_case(9'h0AB, 3'h1, 3'h7, 1'b0);
      rx_case(9'h0D9, 3'h2, 3'h0, 1'b0);
      rx_case(9'h096, 3'h3, 3'h4, 1'b0);
      rx_case(9'h1C3, 3'h7, 3'h0, 1'b0);
      rx_case(9'h069, 3'h3, 3'h1, 1'b1);
      fifo_case();
      final_report();
   end
endmodule
`default_nettype wire
